// *** design/bit_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser; only the second stage is visible
module bit_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level in and out
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic meta; // first stage, read only by second
		logic hold; // second stage
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	// shift one stage per clock
	always_comb
	begin
		s_d.meta = d;
		s_d.hold = s_q.meta;
	end

	// stages clear under reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign q = s_q.hold;
endmodule : bit_sync
`default_nettype wire

// *** design/hdlc_rx_address_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module hdlc_rx_address_status
	import hdlc_rx_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial receive link
	input  wire logic        rx_clk,
	input  wire logic        rx_data,
	// receive queue write side
	input  wire logic        queue_ready,
	output logic      [7:0]  queue_data,
	output logic             queue_valid,
	output logic             queue_last,
	// frame events
	output logic             rx_message_end_irq,
	output logic             cr_is_response
);
	typedef struct packed {
		fstate_e     fst;       // frame hunt or inside frame
		logic [7:0]  mode;      // operating mode register
		logic [7:0]  high_addr_compare_first;      // first high compare, c/r meaning
		logic [7:0]  high_addr_compare_second;      // second high compare, modulus
		logic [7:0]  low_addr_compare_first;      // first low compare
		logic [7:0]  low_addr_compare_second;      // second low compare
		logic [7:0]  rx_frame_status;      // last frame status
		logic [7:0]  rx_control_field;      // last control field
		logic [7:0]  low_addr_compare_first_rx;   // received byte for read-back
		logic [11:0] rbc;       // reported byte count
		logic        cnt_ovf;   // reported count overflow
		logic        clk_prev;  // last sampled link clock
		logic [2:0]  ones;      // run of ones on the line
		logic [5:0]  pipe;      // holds bits that may be a flag
		logic [2:0]  pipe_n;    // bits in the pipe
		logic [7:0]  sh;        // byte assembly
		logic [2:0]  nbit;      // bits in assembly
		logic [15:0] crc;       // running check
		logic [11:0] nbytes;    // bytes in frame, incl. check
		logic        nb_ovf;    // frame ran past the limit
		logic [7:0]  b1;        // first frame bytes
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic [7:0]  b4;
		logic [7:0]  d1;        // delay so check bytes stay out
		logic [7:0]  d2;
		logic [1:0]  dn;
		logic        rx_overflow_flag;       // data lost in this frame
		logic [7:0]  xsh;       // raw assembly, no framing
		logic [2:0]  xn;
		logic [7:0]  q_data;
		logic        q_valid;
		logic        q_last;
		logic        irq;
		logic        upd;       // registers loaded this cycle
		logic        cr_resp;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} st_s;

	st_s s_q;
	st_s s_d;

	logic        rst_s;     // released reset
	logic        rx_clk_s;  // synchronised link clock
	logic        rx_data_s; // synchronised link data
	logic        push_try;  // a data byte wants the queue

	// reset release and link inputs through two flops
	bit_sync u_rst_sync (
		.clk   (clk),
		.rst_n (reset_n),
		.d     (1'b1),
		.q     (rst_s)
	);
	bit_sync u_clk_sync (
		.clk   (clk),
		.rst_n (rst_s),
		.d     (rx_clk),
		.q     (rx_clk_s)
	);
	bit_sync u_data_sync (
		.clk   (clk),
		.rst_n (rst_s),
		.d     (rx_data),
		.q     (rx_data_s)
	);

	// mode decode
	op_mode_e    op;
	logic        address_length_sel;
	logic        addr_mode;
	logic        is_tr;
	logic        is_ext;
	assign op        = op_mode_e'(s_q.mode[MODE_SEL_HI:MODE_SEL_LO]);
	assign address_length_sel       = s_q.mode[MODE_ADDR_LEN];
	assign addr_mode = (op == OP_AUTO) || (op == OP_NONAUTO);
	assign is_tr     = (op == OP_TRANSP);
	assign is_ext    = (op == OP_EXT);

	// address evaluation on the stored header bytes
	logic [7:0]  lo_byte;
	logic        hit1;
	logic        hit2;
	logic        grp;
	logic        uses_hi;
	logic        lo1;
	logic        lo2;
	logic        addr_ok;
	logic [1:0]  hi_code;
	assign lo_byte = address_length_sel ? s_q.b2 : s_q.b1;
	assign hit1 = s_q.b1[7:HIGH_CMP_LSB] == s_q.high_addr_compare_first[7:HIGH_CMP_LSB];
	assign hit2 = s_q.b1[7:HIGH_CMP_LSB] == s_q.high_addr_compare_second[7:HIGH_CMP_LSB];
	assign grp  = (s_q.b1 & GROUP_MASK) == GROUP_ADDR;
	// first register wins, so equal values never give the second code
	assign hi_code = hit1 ? HI_CODE_FIRST :
		(hit2 ? HI_CODE_SECOND : HI_CODE_GROUP);
	assign uses_hi = address_length_sel && (addr_mode || is_tr);
	assign lo1 = lo_byte == s_q.low_addr_compare_first;
	assign lo2 = lo_byte == s_q.low_addr_compare_second;
	assign addr_ok = (!uses_hi || hit1 || hit2 || grp)
		&& (!addr_mode || lo1 || lo2);

	// length, control field and check evaluation
	logic [11:0] min_len;
	logic [11:0] data_bytes;
	logic [7:0]  ctrl1;
	logic [7:0]  ctrl2;
	logic        sframe;
	logic        compress;
	logic [7:0]  ctrl_val;
	logic        frame_ok;
	assign min_len = addr_mode ? (address_length_sel ? MIN_LEN_ADDR16 : MIN_LEN_ADDR8)
		: (address_length_sel ? MIN_LEN_TR1 : MIN_LEN_TR0);
	assign data_bytes = s_q.nbytes - FCS_BYTES;
	assign ctrl1 = uses_hi ? s_q.b3 : s_q.b2;
	assign ctrl2 = uses_hi ? s_q.b4 : s_q.b3;
	assign sframe = (op == OP_AUTO) && (ctrl1[1:0] == CTRL_S_CODE);
	// mod 128 i-frame: low three bits of n(r), p, n(s), zero
	assign compress = (op == OP_AUTO) && s_q.high_addr_compare_second[MODULUS_BIT]
		&& !ctrl1[0];
	assign ctrl_val = compress ? {ctrl2[3:1], ctrl2[0], ctrl1[3:1], 1'b0}
		: ctrl1;
	// bit alignment and data length decide validity
	assign frame_ok = (s_q.nbit == 3'd0) && (data_bytes >= min_len);

	// next-state logic
	always_comb
	begin
		logic       edge_seen;
		logic       bit_in;
		logic       fin;
		logic       fin_abort;
		logic       emit;
		logic       emit_bit;
		logic [7:0] byte_now;
		logic [15:0] crc_n;
		edge_seen = rx_clk_s && !s_q.clk_prev;
		bit_in    = rx_data_s;
		fin       = 1'b0;
		fin_abort = 1'b0;
		emit      = 1'b0;
		emit_bit  = 1'b0;
		byte_now  = {bit_in, s_q.sh[7:1]};
		crc_n     = s_q.crc;
		push_try  = 1'b0;
		s_d = s_q;
		s_d.clk_prev = rx_clk_s;
		s_d.q_valid = 1'b0;
		s_d.q_last  = 1'b0;
		s_d.upd     = 1'b0;
		// status byte and irq one cycle after the registers load
		s_d.irq = s_q.upd;
		if (s_q.upd)
		begin
			s_d.q_valid = 1'b1;
			s_d.q_last  = 1'b1;
			s_d.q_data  = s_q.rx_frame_status;
		end

		// apb: one wait state, answer registered
		if (psel && penable && !s_q.pready)
		begin
			s_d.pready  = 1'b1;
			s_d.pslverr = 1'b0;
			s_d.prdata  = '0;
			unique case (paddr[7:IDX_SHIFT])
				IDX_RX_FRAME_STATUS[5:0]:
					s_d.prdata[7:0] = s_q.rx_frame_status;
				IDX_RX_CONTROL_FIELD[5:0]:
					s_d.prdata[7:0] = s_q.rx_control_field;
				IDX_RX_BYTE_COUNT_LOW[5:0]:
					s_d.prdata[7:0] = s_q.rbc[7:0];
				IDX_RX_BYTE_COUNT_HIGH[5:0]:
					s_d.prdata[7:0] = {3'b000, s_q.cnt_ovf,
						s_q.rbc[11:8]};
				IDX_LOW_ADDR_COMPARE_FIRST[5:0]:
					// address modes keep it write-only
					s_d.prdata[7:0] = addr_mode ? REG_RESET
						: s_q.low_addr_compare_first_rx;
				IDX_RX_MODE[5:0]:
					s_d.prdata[7:0] = s_q.mode;
				IDX_HIGH_ADDR_COMPARE_FIRST[5:0],
				IDX_HIGH_ADDR_COMPARE_SECOND[5:0],
				IDX_LOW_ADDR_COMPARE_SECOND[5:0]:
					s_d.prdata[7:0] = REG_RESET; // write-only
				default:
					s_d.pslverr = 1'b1; // unmapped
			endcase
		end
		else
		begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
		end
		// writes land on the edge that samples pready high
		if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
		begin
			unique case (paddr[7:IDX_SHIFT])
				IDX_HIGH_ADDR_COMPARE_FIRST[5:0]:
					s_d.high_addr_compare_first = pwdata[7:0];
				IDX_HIGH_ADDR_COMPARE_SECOND[5:0]:
					s_d.high_addr_compare_second = pwdata[7:0];
				IDX_LOW_ADDR_COMPARE_FIRST[5:0]:
					s_d.low_addr_compare_first = pwdata[7:0];
				IDX_LOW_ADDR_COMPARE_SECOND[5:0]:
					s_d.low_addr_compare_second = pwdata[7:0];
				IDX_RX_MODE[5:0]:
					s_d.mode = pwdata[7:0];
				default:
					s_d.mode = s_q.mode; // read-only: ignored
			endcase
		end

		// one line bit per rising link clock edge
		if (edge_seen)
		begin
			s_d.ones = bit_in ? ((s_q.ones == MAX_ONES) ? MAX_ONES
				: s_q.ones + 3'd1) : 3'd0;
			if (is_ext)
			begin
				// no framing: raw octets go to the read-back register
				s_d.fst = ST_HUNT;
				s_d.xsh = {bit_in, s_q.xsh[7:1]};
				s_d.xn  = s_q.xn + 3'd1;
				if (s_q.xn == LAST_BIT)
				begin
					s_d.low_addr_compare_first_rx = {bit_in, s_q.xsh[7:1]};
					if (address_length_sel)
					begin
						s_d.q_valid = queue_ready;
						s_d.q_data  = {bit_in, s_q.xsh[7:1]};
					end
				end
			end
			else if (!s_q.mode[MODE_RX_ACTIVE])
				s_d.fst = ST_HUNT;
			else if (s_q.ones == FLAG_ONES && !bit_in)
			begin
				// flag closes any frame and opens the next
				fin = (s_q.fst == ST_FRAME) && (s_q.nbytes != 12'h000);
				s_d.fst    = ST_FRAME;
				s_d.pipe_n = 3'd0;
				s_d.nbit   = 3'd0;
				s_d.nbytes = 12'h000;
				s_d.nb_ovf = 1'b0;
				s_d.crc    = CRC_INIT;
				s_d.dn     = 2'd0;
				s_d.rx_overflow_flag    = 1'b0;
			end
			else if (s_q.ones >= FLAG_ONES && bit_in)
			begin
				// seven ones: the far end aborted
				fin = (s_q.fst == ST_FRAME) && (s_q.nbytes != 12'h000);
				fin_abort = 1'b1;
				s_d.fst = ST_HUNT;
			end
			else if (s_q.fst == ST_FRAME && s_q.ones != STUFF_ONES)
			begin
				// after five ones the next bit stays out of the pipe: a zero is stuffing, a one starts a flag or abort
				s_d.pipe = {bit_in, s_q.pipe[5:1]};
				if (s_q.pipe_n == PIPE_DEPTH)
				begin
					emit     = 1'b1;
					emit_bit = s_q.pipe[0];
				end
				else
					s_d.pipe_n = s_q.pipe_n + 3'd1;
			end
		end

		// byte assembly and check behind the flag pipe
		if (emit)
		begin
			byte_now = {emit_bit, s_q.sh[7:1]};
			crc_n = {1'b0, s_q.crc[15:1]}
				^ ((s_q.crc[0] ^ emit_bit) ? CRC_POLY : 16'h0000);
			s_d.crc  = crc_n;
			s_d.sh   = byte_now;
			s_d.nbit = s_q.nbit + 3'd1;
			if (s_q.nbit == LAST_BIT)
			begin
				s_d.nbytes = (s_q.nbytes == COUNT_MAX) ? COUNT_MAX
					: s_q.nbytes + 12'h001;
				if (s_q.nbytes == COUNT_MAX)
					s_d.nb_ovf = 1'b1;
				unique case (s_q.nbytes)
					12'h000: s_d.b1 = byte_now;
					12'h001: s_d.b2 = byte_now;
					12'h002: s_d.b3 = byte_now;
					12'h003: s_d.b4 = byte_now;
					default: s_d.b4 = s_q.b4;
				endcase
				// two bytes held back so the check bytes never leave
				s_d.d1 = byte_now;
				s_d.d2 = s_q.d1;
				if (s_q.dn == 2'd2)
				begin
					push_try = 1'b1;
					s_d.q_data  = s_q.d2;
					s_d.q_valid = queue_ready;
					if (!queue_ready)
						s_d.rx_overflow_flag = 1'b1;
				end
				else
					s_d.dn = s_q.dn + 2'd1;
			end
		end

		// frame end: load all result registers in one cycle
		if (fin && s_q.nbytes >= min_len
			&& (fin_abort || (addr_ok && !sframe)))
		begin
			s_d.upd  = 1'b1;
			s_d.rx_frame_status = {frame_ok && !fin_abort, s_q.rx_overflow_flag,
				s_q.crc == CRC_GOOD, fin_abort, hi_code,
				s_q.b1[CMD_RESP_BIT], lo1};
			s_d.rbc     = data_bytes;
			s_d.cnt_ovf = s_q.nb_ovf;
			s_d.rx_control_field    = ctrl_val;
			// interpret flag set: a received one means response
			s_d.cr_resp = s_q.high_addr_compare_first[CMD_RESP_BIT] ? s_q.b1[CMD_RESP_BIT]
				: !s_q.b1[CMD_RESP_BIT];
			if (is_tr)
				s_d.low_addr_compare_first_rx = address_length_sel ? s_q.b2 : s_q.b1;
		end
	end

	// state register; constants only under reset
	always_ff @(posedge clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			s_q      <= '0;
			s_q.fst  <= ST_HUNT;
			s_q.crc  <= CRC_INIT;
			s_q.mode <= REG_RESET;
		end
		else
			s_q <= s_d;
	end

	assign prdata             = s_q.prdata;
	assign pready             = s_q.pready;
	assign pslverr            = s_q.pslverr;
	assign queue_data         = s_q.q_data;
	assign queue_valid        = s_q.q_valid;
	assign queue_last         = s_q.q_last;
	assign rx_message_end_irq = s_q.irq;
	assign cr_is_response     = s_q.cr_resp;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_s);

	property p_irq_after_load;
		s_q.upd |=> rx_message_end_irq && queue_last
			&& queue_data == $past(s_q.rx_frame_status);
	endproperty
	a_irq_after_load: assert property (p_irq_after_load)
		else $error("frame end irq not one cycle after load");

	property p_status_last;
		queue_last |-> queue_valid && rx_message_end_irq;
	endproperty
	a_status_last: assert property (p_status_last)
		else $error("status byte not pushed with frame end");

	property p_second_hidden;
		s_q.upd && $past(s_q.high_addr_compare_first[7:2]) == $past(s_q.high_addr_compare_second[7:2])
			|-> s_q.rx_frame_status[3:2] != HI_CODE_SECOND;
	endproperty
	a_second_hidden: assert property (p_second_hidden)
		else $error("second high code with equal compare values");

	property p_no_supervisory;
		s_q.upd && $past(op) == OP_AUTO && !s_q.rx_frame_status[ST_ABORT]
			|-> s_q.rx_control_field[1:0] != CTRL_S_CODE;
	endproperty
	a_no_supervisory: assert property (p_no_supervisory)
		else $error("supervisory frame reported in auto mode");

	property p_cr_meaning;
		s_q.upd |-> cr_is_response == ($past(s_q.high_addr_compare_first[CMD_RESP_BIT])
			? s_q.rx_frame_status[ST_CR] : !s_q.rx_frame_status[ST_CR]);
	endproperty
	a_cr_meaning: assert property (p_cr_meaning)
		else $error("command or response meaning wrong");

	property p_count_limit;
		$rose(s_q.nb_ovf) |-> $past(s_q.nbytes) == COUNT_MAX;
	endproperty
	a_count_limit: assert property (p_count_limit)
		else $error("count overflow before limit");

	property p_lost_byte;
		push_try && !queue_ready |=> s_q.rx_overflow_flag && !queue_valid;
	endproperty
	a_lost_byte: assert property (p_lost_byte)
		else $error("refused byte did not flag overflow");

	property p_short_invalid;
		s_q.upd && s_q.rbc < $past(min_len) |-> !s_q.rx_frame_status[ST_VALID];
	endproperty
	a_short_invalid: assert property (p_short_invalid)
		else $error("short frame marked valid");

	property p_apb_answer;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not a single cycle after access");
endmodule : hdlc_rx_address_status
`default_nettype wire

// *** design/hdlc_rx_pkg.sv ***
`default_nettype none
package hdlc_rx_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] IDX_HIGH_ADDR_COMPARE_FIRST  = 8'h20;
	localparam logic [7:0] IDX_RX_FRAME_STATUS          = 8'h21;
	localparam logic [7:0] IDX_LOW_ADDR_COMPARE_FIRST   = 8'h22;
	localparam logic [7:0] IDX_RX_CONTROL_FIELD         = 8'h23;
	localparam logic [7:0] IDX_RX_BYTE_COUNT_LOW        = 8'h25;
	localparam logic [7:0] IDX_RX_BYTE_COUNT_HIGH       = 8'h26;
	localparam logic [7:0] IDX_HIGH_ADDR_COMPARE_SECOND = 8'h27;
	localparam logic [7:0] IDX_LOW_ADDR_COMPARE_SECOND  = 8'h29;
	localparam logic [7:0] IDX_RX_MODE                  = 8'h2a;
	localparam int         IDX_SHIFT                    = 2;
	localparam logic [7:0] REG_RESET                    = 8'h00;

	// mode register fields
	localparam int MODE_SEL_HI    = 7;
	localparam int MODE_SEL_LO    = 6;
	localparam int MODE_ADDR_LEN  = 5;
	localparam int MODE_RX_ACTIVE = 3;
	// bit 1 of the high compare registers; compare from bit 2 up
	localparam int CMD_RESP_BIT   = 1;
	localparam int MODULUS_BIT    = 1;
	localparam int HIGH_CMP_LSB   = 2;

	// status byte layout
	localparam int ST_VALID    = 7;
	localparam int ST_OVERFLOW = 6;
	localparam int ST_CRC      = 5;
	localparam int ST_ABORT    = 4;
	localparam int ST_CR       = 1;
	localparam int ST_LOW      = 0;
	localparam int CNT_OVF_BIT = 4;

	localparam logic [1:0] HI_CODE_FIRST  = 2'b10;
	localparam logic [1:0] HI_CODE_SECOND = 2'b00;
	localparam logic [1:0] HI_CODE_GROUP  = 2'b01;
	// fe and fc differ only in the c/r bit, so one masked compare
	localparam logic [7:0] GROUP_ADDR     = 8'hfc;
	localparam logic [7:0] GROUP_MASK     = 8'hfd;
	localparam logic [1:0] CTRL_S_CODE    = 2'b01;

	// frame check sequence, lsb first
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hf0b8;

	// frame length limits in bytes
	localparam logic [11:0] MIN_LEN_ADDR16 = 12'h004;
	localparam logic [11:0] MIN_LEN_ADDR8  = 12'h003;
	localparam logic [11:0] MIN_LEN_TR1    = 12'h003;
	localparam logic [11:0] MIN_LEN_TR0    = 12'h002;
	localparam logic [11:0] FCS_BYTES      = 12'h002;
	localparam logic [11:0] COUNT_MAX      = 12'hfff;

	// bit-level framing
	localparam logic [2:0] FLAG_ONES  = 3'd6;
	localparam logic [2:0] STUFF_ONES = 3'd5;
	localparam logic [2:0] MAX_ONES   = 3'd7;
	localparam logic [2:0] PIPE_DEPTH = 3'd6;
	localparam logic [2:0] LAST_BIT   = 3'd7;

	typedef enum logic [1:0] {
		OP_AUTO    = 2'b00,
		OP_NONAUTO = 2'b01,
		OP_TRANSP  = 2'b10,
		OP_EXT     = 2'b11
	} op_mode_e;

	typedef enum logic [1:0] {
		ST_HUNT  = 2'b01,
		ST_FRAME = 2'b10
	} fstate_e;
endpackage : hdlc_rx_pkg
`default_nettype wire

// *** verification/hdlc_station.sv ***
`timescale 1ns/1ps
`default_nettype none
// remote station: flags, zero insertion, check sequence, abort
module hdlc_station
(
	// link toward the receiver
	output logic rx_clk,
	output logic rx_data
);
	int          ones; // run of ones for zero insertion
	logic [15:0] crc;  // running check sequence

	// clock stands still between frames, line idles high
	initial
	begin
		rx_clk  = 1'b0;
		rx_data = 1'b1;
		ones    = 0;
	end

	// one link bit: low half, then rising edge samples it
	task automatic put(input logic d);
		rx_data = d;
		#80 rx_clk = 1'b1;
		#80 rx_clk = 1'b0;
	endtask : put

	// opening or closing flag, never stuffed
	task automatic flag();
		for (int i = 0; i < 8; i++)
			put(i != 0 && i != 7);
		ones = 0;
	endtask : flag

	// data bit, crc update, zero after five ones
	task automatic dbit(input logic d, input bit upd);
		if (upd)
			crc = (crc >> 1) ^ ((crc[0] ^ d) ? 16'h8408 : 16'h0000);
		put(d);
		ones = d ? ones + 1 : 0;
		if (ones == 5)
		begin
			put(1'b0);
			ones = 0;
		end
	endtask : dbit

	// bytes lsb first, stray bits, then check sequence or abort
	task automatic send(input logic [47:0] b, input int n, input bit bad,
		input bit abt, input int xb);
		logic [15:0] fcs;
		#7; // phase kept apart from the system clock
		flag();
		crc = 16'hffff;
		for (int i = 0; i < n * 8; i++)
			dbit(b[i], 1'b1);
		for (int i = 0; i < xb; i++)
			dbit(1'b0, 1'b1);
		fcs = ~crc ^ {15'h0000, bad};
		if (abt)
			for (int i = 0; i < 8; i++)
				put(1'b1); // seven or more ones end the frame
		else
			for (int i = 0; i < 16; i++)
				dbit(fcs[i], 1'b0);
		flag();
		rx_data = 1'b1;
	endtask : send
endmodule : hdlc_station
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// count a comparison; report and count a mismatch
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s expected %h seen %h", nm, e, g); \
end end
module tb
	import hdlc_rx_pkg::*;
;
	typedef struct {
		logic [7:0]  mode; // mode register value
		int          n;    // data bytes
		logic [47:0] b;    // bytes, first in low octet
		bit          bad;  // corrupt check sequence
		bit          abt;  // abort in place of check
		int          xb;   // stray bits after data
		bit          rep;  // frame should be reported
		logic [7:0]  mask; // status bits that matter
		logic [7:0]  st;   // expected status
		logic [8:0]  ctl;  // [8] check, control byte
		logic [12:0] cnt;  // [12] check, byte count
		logic        cr;   // interpreted c/r
		logic [8:0]  ral;  // [8] check, first low read
	} row_s;

	logic        clk, reset_n, psel, penable, pwrite, q_ready;
	logic [7:0]  paddr, last_q, v, h;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, rx_clk, rx_data, queue_valid;
	logic        queue_last, irq, cr_resp, err;
	logic [7:0]  queue_data;
	int          mismatches, cmp_count, irqs, cyc;
	row_s        rows [14];
	// registers that must read back as their reset value
	logic [7:0]  ridx [5] = '{IDX_RX_FRAME_STATUS, IDX_RX_CONTROL_FIELD,
		IDX_RX_BYTE_COUNT_LOW, IDX_RX_BYTE_COUNT_HIGH, IDX_RX_MODE};

	hdlc_rx_address_status DUT (.clk(clk), .reset_n(reset_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_clk(rx_clk), .rx_data(rx_data),
		.queue_ready(q_ready), .queue_data(queue_data),
		.queue_valid(queue_valid), .queue_last(queue_last),
		.rx_message_end_irq(irq), .cr_is_response(cr_resp));
	hdlc_station st (.rx_clk(rx_clk), .rx_data(rx_data));

	// 50 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// frame-end pulses, last queued byte, hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (irq === 1'b1)
			irqs++;
		if (queue_valid === 1'b1 && queue_last === 1'b1)
			last_q = queue_data;
		if (cyc == 40000)
		begin
			mismatches++;
			$display("Error run length expected finish seen hang");
			summarize();
		end
	end

	// verdict and end of run
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		paddr   <= 8'(idx << IDX_SHIFT);
		pwrite  <= w;
		pwdata  <= {24'h000000, wd};
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		// wait for the answer; only the run timeout ends a hang
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so no strobe is driven twice in a step
		@(posedge clk);
	endtask : apb

	// compare values and link address registers
	task automatic setup();
		apb(1'b1, IDX_HIGH_ADDR_COMPARE_FIRST, 8'h12, v);
		apb(1'b1, IDX_HIGH_ADDR_COMPARE_SECOND, 8'h22, v);
		apb(1'b1, IDX_LOW_ADDR_COMPARE_FIRST, 8'h31, v);
		apb(1'b1, IDX_LOW_ADDR_COMPARE_SECOND, 8'h32, v);
	endtask : setup

	// send one frame and check what the host sees afterwards
	task automatic run(input row_s r);
		int q0;
		apb(1'b1, IDX_RX_MODE, r.mode, v);
		q0 = irqs;
		st.send(r.b, r.n, r.bad, r.abt, r.xb);
		for (int k = 0; k < 300 && irqs == q0; k++)
			@(posedge clk);
		// next request starts just after a rising edge
		@(posedge clk);
		`CHK("reported", r.rep, irqs != q0)
		if (r.rep)
		begin
			apb(1'b0, IDX_RX_FRAME_STATUS, 8'h00, v);
			`CHK("status", r.st, v & r.mask)
			if (q_ready)
				`CHK("queued status", r.st, last_q & r.mask)
			apb(1'b0, IDX_RX_BYTE_COUNT_LOW, 8'h00, v);
			apb(1'b0, IDX_RX_BYTE_COUNT_HIGH, 8'h00, h);
			if (r.cnt[12])
				`CHK("count", {1'b0, r.cnt[11:0]}, {h[4:0], v})
			apb(1'b0, IDX_RX_CONTROL_FIELD, 8'h00, v);
			if (r.ctl[8])
				`CHK("control", r.ctl[7:0], v)
			apb(1'b0, IDX_LOW_ADDR_COMPARE_FIRST, 8'h00, v);
			if (r.ral[8])
				`CHK("low first read", r.ral[7:0], v)
			if (r.mask[1])
				`CHK("cr meaning", r.cr, cr_resp)
		end
	endtask : run

	// main sequence
	initial
	begin
		reset_n = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		q_ready = 1'b1;
		rows = '{
		'{8'h68,4,48'haa053110,0,0,0,1,8'hff,8'ha9,9'h105,13'h1004,0,9'h100},
		'{8'h68,4,48'hbb073222,0,0,0,1,8'hff,8'ha2,9'h107,13'h1004,1,9'h000},
		'{8'h68,5,48'h020109_31fe,0,0,0,1,8'hff,8'ha7,9'h109,13'h1005,1,0},
		'{8'h68,3,48'h053110,0,0,0,1,8'h80,8'h00,9'h000,13'h1003,0,9'h000},
		'{8'h68,1,48'h10,0,0,0,0,8'h00,8'h00,9'h000,13'h0000,0,9'h000},
		'{8'h68,4,48'haa053140,0,0,0,0,8'h00,8'h00,9'h000,13'h0000,0,9'h000},
		'{8'h68,4,48'haa053110,1,0,0,1,8'h20,8'h00,9'h105,13'h1004,0,9'h000},
		'{8'h68,5,48'haa053110,0,1,0,1,8'h10,8'h10,9'h000,13'h0000,0,9'h000},
		'{8'h68,4,48'haa053110,0,0,3,1,8'h80,8'h00,9'h000,13'h0000,0,9'h000},
		'{8'h48,3,48'h441331,0,0,0,1,8'hf1,8'ha1,9'h113,13'h1003,0,9'h100},
		'{8'ha8,3,48'h665512,0,0,0,1,8'hfc,8'ha8,9'h166,13'h1003,0,9'h155},
		'{8'h88,2,48'h8877,0,0,0,1,8'hf0,8'ha0,9'h188,13'h1002,0,9'h177},
		'{8'h28,4,48'h070a3110,0,0,0,1,8'hff,8'ha9,9'h17a,13'h1004,0,0},
		'{8'h28,4,48'h00013110,0,0,0,0,8'h00,8'h00,9'h000,13'h0000,0,0}};
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		setup();
		// table rows: modes, matches, lengths, faults
		for (int i = 0; i < 14; i++)
		begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		// equal high values must keep the first-register code
		apb(1'b1, IDX_HIGH_ADDR_COMPARE_SECOND, 8'h12, v);
		run(rows[0]);
		$display("equal high values done");
		// one-byte auto address: first high value must be zero
		apb(1'b1, IDX_HIGH_ADDR_COMPARE_FIRST, 8'h00, v);
		run('{8'h08,3,48'h440332,0,0,0,1,8'hf1,8'ha0,9'h103,13'h1003,0,
			9'h100});
		$display("one-byte auto address done");
		// queue refusing bytes marks the frame overflowed
		q_ready <= 1'b0;
		run('{8'h68,4,48'haa053110,0,0,0,1,8'h40,8'h40,0,0,0,0});
		q_ready <= 1'b1;
		apb(1'b1, IDX_RX_FRAME_STATUS, 8'h00, v);
		apb(1'b0, IDX_RX_FRAME_STATUS, 8'h00, v);
		`CHK("status after write", 8'h40, v & 8'h40)
		apb(1'b0, 8'h00, 8'h00, v);
		`CHK("unmapped error", 1'b1, err)
		apb(1'b0, IDX_HIGH_ADDR_COMPARE_FIRST, 8'h00, v);
		`CHK("write-only read", 8'h00, v)
		$display("overflow and access done");
		// second reset in mid-run clears every register
		reset_n <= 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ridx[i])
		begin
			apb(1'b0, ridx[i], 8'h00, v);
			`CHK("reset value", REG_RESET, v)
		end
		// receiver stays inactive after reset
		run('{8'h00,4,48'haa053110,0,0,0,0,0,0,0,0,0,0});
		$display("reset done");
		// extended transparent: raw octets, the last one is the flag
		run('{8'he0,4,48'haa053110,0,1,0,0,0,0,0,0,0,0});
		apb(1'b0, IDX_LOW_ADDR_COMPARE_FIRST, 8'h00, v);
		`CHK("raw octet", 8'h7e, v)
		$display("extended transparent done");
		summarize();
	end
endmodule : tb
`default_nettype wire
